// ===== rtl/three_phase_firing_sequencer.sv
// divider, phase generator, modulator, commutation and run/trip logic of the inverter driver
`timescale 1ns/1ns
`include "firing_cfg.svh"

// Operation
// - divide oscillator pulses by 16, 8 or 4 for single, double, quadruple range
// - divided pulse rate is six times the output fundamental
// - generate three square phases and their inverses
// - phases spaced 120 degrees, second after first, third after second
// - first phase passes to output A in both directions
// - forward maps second/third to B/C, reverse to C/B; inverses too
// - chop modulates the centre of every half cycle
// - at low frequency chop modulates the whole cycle
// - commutation logic fires four switches per phase following the command
// - frequency feedback runs at half the oscillator rate
// - bus voltage trip trips all phases
// - phase current above limit overrides firing at once
// - instantaneous over-current halts firing and fires all mains together
// - start, stop and reversal wait for minimum voltage status low
// - run-ready goes low when ready, lifting reference clamp
// - firing enable low starts, high stops firing except forced over-current, current-limit and trip pulses
// - reversal request is active low and preconditioned before reversing
// - primary trips shut down through primary commutating path
// - over-current trip signals start trip and latch lockout, secondary path
// - running lit without fault; fault clears it, reset-needed until stop
// - phase logic runs at 1/96, 1/48 or 1/24 of oscillator
module three_phase_firing_sequencer
  import firing_pkg::*;
(
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 reset_n,
  // speed oscillator and range
  input  wire logic                 osc_pulse,
  input  wire logic                 range_single,
  input  wire logic                 range_double,
  input  wire logic                 range_quadruple,
  output logic                      freq_feedback,
  output logic                      divided_pulse,
  // modulation
  input  wire logic                 chop,
  input  wire logic                 low_frequency,
  output firing_pkg::phase_set_t    phase_cmd,
  output firing_pkg::phase_set_t    phase_cmd_inv,
  // operator and coordination
  input  wire logic                 start_request_n,
  input  wire logic                 reverse_request_n,
  input  wire logic                 min_voltage_n,
  output logic                      run_ready_n,
  output logic                      firing_enable_n,
  output logic                      running,
  output logic                      reset_needed,
  output logic                      reverse_active,
  // protection
  input  wire logic                 bus_voltage_trip,
  input  wire logic                 primary_trip_a_n,
  input  wire logic                 primary_trip_b_n,
  input  wire logic                 overcurrent_trip_n,
  input  wire logic                 ioc_detect,
  input  wire logic [2:0]           phase_current_high,
  output logic                      overcurrent_lockout,
  // firing commands
  output firing_pkg::fire_set_t     fire
);
  import firing_pkg::*;

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_meta;
  logic rst_sync_n;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // centre steps of the half cycle that starts at step first and of the half cycle after it
  function automatic logic centre_of(input step_t s, input step_t first);
    logic r;
    r = 1'b0;
    case (first)
      ST0:     r = (s == ST1) || (s == ST4);
      ST2:     r = (s == ST3) || (s == ST0);
      ST4:     r = (s == ST5) || (s == ST2);
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // chop gate for one phase: whole cycle at low frequency, centre otherwise
  function automatic logic chop_gate(input logic ph, input logic ctr, input logic lf, input logic ch);
    return ph & (ch | ~(lf | ctr));
  endfunction

  // ----------------------------------------
  // oscillator edge, feedback and divider
  // ----------------------------------------
  logic       osc_prev;
  logic       osc_edge;
  logic [3:0] div_count;
  logic [3:0] div_last;
  assign osc_edge = osc_pulse & ~osc_prev;
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      osc_prev <= 1'b0;
    end else begin
      osc_prev <= osc_pulse;
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      freq_feedback <= 1'b0;
    end else if (osc_edge) begin
      freq_feedback <= ~freq_feedback;
    end
  end

  // divisor from range select, quadruple wins
  assign div_last = range_quadruple ? `DIV_LAST_QUAD : (range_double ? `DIV_LAST_DOUBLE : `DIV_LAST_SINGLE);

  // count oscillator pulses; a range change keeps the count, wrapping at the next pulse if past the new limit
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      div_count     <= `DIV_ZERO;
      divided_pulse <= 1'b0;
    end else begin
      divided_pulse <= 1'b0;
      if (osc_edge) begin
        if (div_count >= div_last) begin
          div_count     <= `DIV_ZERO;
          divided_pulse <= 1'b1;
        end else begin
          div_count <= div_count + `DIV_STEP;
        end
      end
    end
  end

  // ----------------------------------------
  // six-step phase generator
  // ----------------------------------------
  step_t step;
  step_t next_step;
  logic  ph_x;
  logic  ph_y;
  logic  ph_z;
  // one step per divided pulse, six steps per cycle
  always_comb begin
    case (step)
      ST0:     next_step = ST1;
      ST1:     next_step = ST2;
      ST2:     next_step = ST3;
      ST3:     next_step = ST4;
      ST4:     next_step = ST5;
      ST5:     next_step = ST0;
      default: next_step = ST0;
    endcase
  end

  // six divided pulses per output cycle
  // 6 x 16, 8 or 4 oscillator pulses per cycle
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      step <= ST0;
    end else if (divided_pulse) begin
      step <= next_step;
    end
  end

  // square phases, high for three of six steps
  // each phase lags the previous by two steps
  assign ph_x = (step == ST0) || (step == ST1) || (step == ST2);
  assign ph_y = (step == ST2) || (step == ST3) || (step == ST4);
  assign ph_z = (step == ST4) || (step == ST5) || (step == ST0);

  // ----------------------------------------
  // run, stop and fault sequencing
  // ----------------------------------------
  run_state_t run_state;
  logic       primary_trip;
  logic       ioc_event;
  logic       any_fault;
  // primary trips kept apart from over-current handling
  assign primary_trip = ~primary_trip_a_n | ~primary_trip_b_n | bus_voltage_trip;
  assign ioc_event    = ~overcurrent_trip_n | ioc_detect;
  assign any_fault    = primary_trip | ioc_event | overcurrent_lockout;

  // lockout latches, cleared only by stop/reset with no new event
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      overcurrent_lockout <= 1'b0;
    end else if (ioc_event) begin
      overcurrent_lockout <= 1'b1;
    end else if (start_request_n) begin
      overcurrent_lockout <= 1'b0;
    end
  end

  // start held low by the controller while running
  // start and stop only at minimum voltage
  // fault drops running and holds reset-needed until stop
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      run_state <= RUN_IDLE;
    end else begin
      case (run_state)
        RUN_IDLE: begin
          if (!start_request_n) begin
            run_state <= any_fault ? RUN_FAULT : RUN_START;
          end
        end
        RUN_START: begin
          if (any_fault) begin
            run_state <= RUN_FAULT;
          end else if (start_request_n) begin
            run_state <= RUN_IDLE;
          end else if (!min_voltage_n) begin
            run_state <= RUN_ON;
          end
        end
        RUN_ON: begin
          if (any_fault) begin
            run_state <= RUN_FAULT;
          end else if (start_request_n && !min_voltage_n) begin
            run_state <= RUN_IDLE;
          end
        end
        RUN_FAULT: begin
          if (start_request_n) begin
            run_state <= RUN_IDLE;
          end
        end
        default: run_state <= RUN_IDLE;
      endcase
    end
  end

  // firing enable follows the run state
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      running         <= 1'b0;
      reset_needed    <= 1'b0;
      run_ready_n     <= 1'b1;
      firing_enable_n <= 1'b1;
    end else begin
      running         <= (run_state == RUN_ON) && !any_fault;
      reset_needed    <= (run_state == RUN_FAULT);
      run_ready_n     <= !((run_state == RUN_ON) && !any_fault);
      firing_enable_n <= !((run_state == RUN_ON) && !any_fault);
    end
  end

  // ----------------------------------------
  // direction
  // ----------------------------------------
  // request sampled only at minimum voltage, so the swap never
  // lands on a loaded output
  // reversal gated on minimum voltage
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      reverse_active <= 1'b0;
    end else if (!min_voltage_n) begin
      reverse_active <= ~reverse_request_n;
    end
  end

  // ----------------------------------------
  // phase mapping and modulator
  // ----------------------------------------
  logic ph_b;
  logic ph_c;
  logic ctr_a;
  logic ctr_b;
  logic ctr_c;
  // first phase is always output A
  assign ph_b  = reverse_active ? ph_z : ph_y;
  assign ph_c  = reverse_active ? ph_y : ph_z;
  assign ctr_a = centre_of(step, ST0);
  assign ctr_b = centre_of(step, reverse_active ? ST4 : ST2);
  assign ctr_c = centre_of(step, reverse_active ? ST2 : ST4);

  // centre of each half cycle chopped
  // whole cycle chopped at low frequency
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      phase_cmd     <= '0;
      phase_cmd_inv <= '0;
    end else begin
      phase_cmd.a     <= chop_gate(ph_x, ctr_a, low_frequency, chop);
      phase_cmd.b     <= chop_gate(ph_b, ctr_b, low_frequency, chop);
      phase_cmd.c     <= chop_gate(ph_c, ctr_c, low_frequency, chop);
      phase_cmd_inv.a <= chop_gate(~ph_x, ctr_a, low_frequency, chop);
      phase_cmd_inv.b <= chop_gate(~ph_b, ctr_b, low_frequency, chop);
      phase_cmd_inv.c <= chop_gate(~ph_c, ctr_c, low_frequency, chop);
    end
  end

  // ----------------------------------------
  // commutation and firing
  // ----------------------------------------
  phase_set_t pos_prev;
  phase_set_t neg_prev;
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pos_prev <= '0;
      neg_prev <= '0;
    end else begin
      pos_prev <= phase_cmd;
      neg_prev <= phase_cmd_inv;
    end
  end

  // one phase: mains follow the command, commutating switch pulses when
  // its main drops; current limit and primary trip force commutation
  function automatic fire_t fire_phase(input logic pos, input logic neg, input logic pp, input logic np,
                                       input logic ilim, input logic en, input logic ptrip, input logic ioc);
    fire_t f;
    f = '0;
    if (ioc) begin
      f.main_hi = 1'b1;
      f.main_lo = 1'b1;
    end else if (ptrip || ilim) begin
      f.comm_hi = pp;
      f.comm_lo = np;
    end else if (en) begin
      f.main_hi = pos;
      f.main_lo = neg;
      f.comm_hi = pp & ~pos;
      f.comm_lo = np & ~neg;
    end
    return f;
  endfunction

  // four switches per phase follow the command
  // over-limit current overrides its phase at once
  // no command firing while enable is high; over-current, current limit and primary trip still force switches
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      fire <= '0;
    end else begin
      fire.a <= fire_phase(phase_cmd.a, phase_cmd_inv.a, pos_prev.a, neg_prev.a, phase_current_high[0],
                           !firing_enable_n, primary_trip, ioc_event);
      fire.b <= fire_phase(phase_cmd.b, phase_cmd_inv.b, pos_prev.b, neg_prev.b, phase_current_high[1],
                           !firing_enable_n, primary_trip, ioc_event);
      fire.c <= fire_phase(phase_cmd.c, phase_cmd_inv.c, pos_prev.c, neg_prev.c, phase_current_high[2],
                           !firing_enable_n, primary_trip, ioc_event);
    end
  end

endmodule

// ===== rtl/firing_cfg.svh
// timing and divider constants for the three-phase firing sequencer
`ifndef FIRING_CFG_SVH
`define FIRING_CFG_SVH
`define DIV_LAST_SINGLE 4'hf
`define DIV_LAST_DOUBLE 4'h7
`define DIV_LAST_QUAD   4'h3
`define DIV_ZERO        4'h0
`define DIV_STEP        4'h1
`endif

// ===== rtl/firing_pkg.sv
// types shared by the three-phase firing sequencer
package firing_pkg;
  typedef struct packed {
    logic a;
    logic b;
    logic c;
  } phase_set_t;
  typedef struct packed {
    logic main_hi;
    logic main_lo;
    logic comm_hi;
    logic comm_lo;
  } fire_t;
  typedef struct packed {
    fire_t a;
    fire_t b;
    fire_t c;
  } fire_set_t;
  typedef enum logic [5:0] {
    ST0 = 6'h01,
    ST1 = 6'h02,
    ST2 = 6'h04,
    ST3 = 6'h08,
    ST4 = 6'h10,
    ST5 = 6'h20
  } step_t;
  typedef enum logic [3:0] {
    RUN_IDLE  = 4'h1,
    RUN_START = 4'h2,
    RUN_ON    = 4'h4,
    RUN_FAULT = 4'h8
  } run_state_t;
endpackage

// ===== dv/fire_seq_monitor.sv
// port assertions for the three-phase firing sequencer
`timescale 1ns/1ns
module fire_seq_monitor
  import firing_pkg::*;
(
  // clock, reset and inputs
  input wire logic                  core_clk,
  input wire logic                  reset_n,
  input wire logic                  osc_pulse,
  input wire logic                  reverse_request_n,
  input wire logic                  min_voltage_n,
  input wire logic                  bus_voltage_trip,
  input wire logic                  ioc_detect,
  // outputs
  input wire logic                  freq_feedback,
  input wire logic                  divided_pulse,
  input wire firing_pkg::phase_set_t phase_cmd,
  input wire firing_pkg::phase_set_t phase_cmd_inv,
  input wire logic                  run_ready_n,
  input wire logic                  firing_enable_n,
  input wire logic                  running,
  input wire logic                  reset_needed,
  input wire logic                  reverse_active,
  input wire logic                  overcurrent_lockout,
  input wire firing_pkg::fire_set_t fire
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  property p_div_pulse; divided_pulse |=> !divided_pulse; endproperty
  a_div_pulse: assert property (p_div_pulse) else $error("divided pulse too long");
  property p_fb_toggle; $rose(osc_pulse) |=> $changed(freq_feedback); endproperty
  a_fb_toggle: assert property (p_fb_toggle) else $error("feedback missed a toggle");
  property p_fb_hold; !$rose(osc_pulse) |=> $stable(freq_feedback); endproperty
  a_fb_hold: assert property (p_fb_hold) else $error("feedback moved on its own");
  property p_excl; (phase_cmd & phase_cmd_inv) == 3'h0; endproperty
  a_excl: assert property (p_excl) else $error("phase and inverse both high");
  property p_en; firing_enable_n == run_ready_n; endproperty
  a_en: assert property (p_en) else $error("firing enable differs from run ready");
  property p_ready; running |-> !run_ready_n; endproperty
  a_ready: assert property (p_ready) else $error("running without run ready");
  property p_fault; reset_needed |-> !running; endproperty
  a_fault: assert property (p_fault) else $error("running while reset needed");
  property p_bus; bus_voltage_trip |-> ##[1:3] !running; endproperty
  a_bus: assert property (p_bus) else $error("bus trip left drive running");
  property p_ioc; ioc_detect |-> ##[1:3] ((fire & 12'hccc) == 12'hccc); endproperty
  a_ioc: assert property (p_ioc) else $error("mains not fired together");
  property p_lock; ioc_detect |-> ##[1:2] overcurrent_lockout; endproperty
  a_lock: assert property (p_lock) else $error("lockout not latched");
  property p_rev; !min_voltage_n |=> reverse_active == !$past(reverse_request_n); endproperty
  a_rev: assert property (p_rev) else $error("direction not taken");
  property p_rev_hold; min_voltage_n |=> $stable(reverse_active); endproperty
  a_rev_hold: assert property (p_rev_hold) else $error("direction changed above minimum");
endmodule

bind three_phase_firing_sequencer fire_seq_monitor mon (.core_clk, .reset_n, .osc_pulse, .reverse_request_n,
  .min_voltage_n, .bus_voltage_trip, .ioc_detect, .freq_feedback, .divided_pulse, .phase_cmd, .phase_cmd_inv,
  .run_ready_n, .firing_enable_n, .running, .reset_needed, .reverse_active, .overcurrent_lockout, .fire);

// ===== dv/power_stage_model.sv
// behavioural power stage that reports phase over-current when told to
`timescale 1ns/1ns
module power_stage_model
  import firing_pkg::*;
(
  // clock and firing
  input  wire logic                  core_clk,
  input  wire firing_pkg::fire_set_t fire,
  // scenario control and current sense
  input  wire logic [2:0]            overload,
  output logic [2:0]                 phase_current_high
);
  logic [2:0] conducting;

  assign conducting = {fire.c.main_hi | fire.c.main_lo, fire.b.main_hi | fire.b.main_lo,
                       fire.a.main_hi | fire.a.main_lo};
  initial phase_current_high = 3'h0;
  always @(posedge core_clk) begin
    // held while overloaded so removing the mains does not make it oscillate
    phase_current_high <= overload & (phase_current_high | conducting);
  end
endmodule

// ===== dv/testbench.sv
// self-checking testbench for the three-phase firing sequencer
`timescale 1ns/1ns
module testbench;
  import firing_pkg::*;
  logic       core_clk = 1'b0, reset_n = 1'b0, osc_pulse = 1'b0, chop = 1'b1, low_frequency = 1'b0;
  logic       range_single = 1'b1, range_double = 1'b0, range_quadruple = 1'b0;
  logic       start_request_n = 1'b1, reverse_request_n = 1'b1, min_voltage_n = 1'b1;
  logic       bus_voltage_trip = 1'b0, ioc_detect = 1'b0, overcurrent_trip_n = 1'b1;
  logic       primary_trip_a_n = 1'b1, primary_trip_b_n = 1'b1;
  logic [2:0] overload = 3'h0, phase_current_high;
  logic       freq_feedback, divided_pulse, run_ready_n, firing_enable_n, running, reset_needed;
  logic       reverse_active, overcurrent_lockout, fb, fbq;
  phase_set_t phase_cmd, phase_cmd_inv, p, q;
  phase_set_t ph [12];
  phase_set_t pi [12];
  fire_set_t  fire;
  logic [11:0] ndiv, nz, na, nfb;
  int          mismatches = 0, checks_done = 0, k;

  three_phase_firing_sequencer dut (.core_clk, .reset_n, .osc_pulse, .range_single, .range_double,
    .range_quadruple, .freq_feedback, .divided_pulse, .chop, .low_frequency, .phase_cmd, .phase_cmd_inv,
    .start_request_n, .reverse_request_n, .min_voltage_n, .run_ready_n, .firing_enable_n, .running,
    .reset_needed, .reverse_active, .bus_voltage_trip, .primary_trip_a_n, .primary_trip_b_n,
    .overcurrent_trip_n, .ioc_detect, .phase_current_high, .overcurrent_lockout, .fire);
  power_stage_model stage (.core_clk, .fire, .overload, .phase_current_high);

  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) if (divided_pulse === 1'b1) ndiv <= ndiv + 12'h1;
  // rising edges of the feedback train, for the reference rate check
  always @(posedge core_clk) begin
    fbq <= freq_feedback;
    if (freq_feedback === 1'b1 && fbq === 1'b0) nfb <= nfb + 12'h1;
  end

  // ------------------------------------------
  // tasks
  // ------------------------------------------
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic osc(input int n);
    repeat (n) begin
      osc_pulse = 1'b1;
      tick(1);
      osc_pulse = 1'b0;
      tick(1);
    end
  endtask
  // one phase step in quadruple range, sampled once the registered command settles
  task automatic step(output phase_set_t c, output phase_set_t ci);
    osc(4);
    tick(3);
    c = phase_cmd;
    ci = phase_cmd_inv;
  endtask
  task automatic fault_run(input int src);
    start_request_n = 1'b0;
    tick(6);
    chk(running, 1'b1, "running");
    {bus_voltage_trip, primary_trip_a_n, primary_trip_b_n, overcurrent_trip_n, ioc_detect} = 5'h0e ^ (5'h10 >> src);
    tick(3);
    chk({running, reset_needed}, 2'b01, "fault state");
    chk(overcurrent_lockout, src > 2, "lockout");
    if (src < 3) chk(fire & 12'hccc, 12'h0, "mains off");
    else chk(fire & 12'hccc, 12'hccc, "mains all on");
    {bus_voltage_trip, primary_trip_a_n, primary_trip_b_n, overcurrent_trip_n, ioc_detect} = 5'h0e;
    start_request_n = 1'b1;
    tick(3);
    chk({reset_needed, overcurrent_lockout}, 2'b00, "cleared");
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ------------------------------------------
  // tests
  // ------------------------------------------
  initial begin
    repeat (4) @(posedge core_clk);
    #1 reset_n = 1'b1;
    tick(3);
    for (int i = 0; i < 3; i++) begin
      {range_single, range_double, range_quadruple} = 3'b100 >> i;
      tick(2);
      ndiv = 12'h0;
      fb = freq_feedback;
      osc(48);
      tick(3);
      chk(ndiv, 12'(3 << i), "divided pulses");
      chk(freq_feedback, fb, "feedback even");
      osc(1);
      tick(2);
      chk(freq_feedback, !fb, "feedback toggle");
    end
    $display("test divider done");
    for (int r = 0; r < 2; r++) begin
      reverse_request_n = (r == 0);
      min_voltage_n = 1'b0;
      tick(2);
      chk(reverse_active, r == 1, "direction");
      min_voltage_n = 1'b1;
      nfb = 12'h0;
      for (int s = 0; s < 12; s++) step(ph[s], pi[s]);
      // two output cycles in quadruple range, twelve feedback pulses each
      chk(nfb, 12'h18, "feedback rate");
      // second lags first by two steps forward, third does in reverse
      k = r ? 2 : 4;
      na = 12'h0;
      for (int s = 0; s < 6; s++) begin
        na = na + ph[s].a;
        chk(ph[s], ph[s + 6], "cycle repeat");
        chk(pi[s] ^ ph[s], 12'h7, "inverse");
        chk({ph[s].b, ph[s].c}, {ph[(s + k) % 6].a, ph[(s + 6 - k) % 6].a}, "phase order");
      end
      chk(na, 12'h3, "square phase");
      reverse_request_n = ~reverse_request_n;
      tick(2);
      chk(reverse_active, r == 1, "direction hold");
    end
    $display("test phases done");
    chop = 1'b0;
    for (int lf = 0; lf < 2; lf++) begin
      low_frequency = (lf == 1);
      nz = 12'h0;
      for (int s = 0; s < 6; s++) begin
        step(p, q);
        nz = nz + !(p.a | q.a) + !(p.b | q.b) + !(p.c | q.c);
      end
      chk(nz, lf ? 12'h12 : 12'h6, "chopped steps");
    end
    {chop, low_frequency} = 2'b10;
    $display("test chop done");
    start_request_n = 1'b0;
    tick(6);
    chk(running, 1'b0, "start above minimum");
    min_voltage_n = 1'b0;
    tick(4);
    chk({running, run_ready_n, firing_enable_n}, 3'b100, "run");
    step(p, q);
    chk({fire.a.main_hi, fire.a.main_lo}, {p.a, q.a}, "mains follow");
    overload = 3'b001;
    osc(8);
    tick(2);
    chk({fire.a.main_hi, fire.a.main_lo}, 2'b00, "current limit");
    overload = 3'h0;
    start_request_n = 1'b1;
    tick(3);
    chk(running, 1'b0, "stop");
    for (int src = 0; src < 5; src++) fault_run(src);
    $display("test run done");
    test_done;
  end

  initial begin
    #100000;
    mismatches++;
    test_done;
  end
endmodule
